// >>> pkg/sjt_defs.svh
// constants of the sram boundary-scan test access port
`ifndef SJT_DEFS_SVH
`define SJT_DEFS_SVH

`define SJT_IR_W     3
`define SJT_ID_W     32
`define SJT_BSR_W    107
`define SJT_OE_BIT   47
`define SJT_IR_CAP   2'h1

`define SJT_IR_EXTEST  3'h0
`define SJT_IR_IDCODE  3'h1
`define SJT_IR_SAMPLEZ 3'h2
`define SJT_IR_RSV3    3'h3
`define SJT_IR_SAMPLE  3'h4
`define SJT_IR_RSV5    3'h5
`define SJT_IR_RSV6    3'h6
`define SJT_IR_BYPASS  3'h7

`endif

// >>> pkg/sjt_pkg.sv
// types of the sram boundary-scan test access port
`include "sjt_defs.svh"

package sjt_pkg;

	typedef enum logic [3:0] {
		ST_E2D  = 4'h0,
		ST_E1D  = 4'h1,
		ST_SDR  = 4'h2,
		ST_PDR  = 4'h3,
		ST_SIS  = 4'h4,
		ST_UDR  = 4'h5,
		ST_CDR  = 4'h6,
		ST_SDS  = 4'h7,
		ST_E2I  = 4'h8,
		ST_E1I  = 4'h9,
		ST_SIR  = 4'ha,
		ST_PIR  = 4'hb,
		ST_RTI  = 4'hc,
		ST_UIR  = 4'hd,
		ST_CIR  = 4'he,
		ST_TLR  = 4'hf
	} sjt_state_t;

	typedef enum logic [2:0] {
		IR_EXTEST  = `SJT_IR_EXTEST,
		IR_IDCODE  = `SJT_IR_IDCODE,
		IR_SAMPLEZ = `SJT_IR_SAMPLEZ,
		IR_RSV3    = `SJT_IR_RSV3,
		IR_SAMPLE  = `SJT_IR_SAMPLE,
		IR_RSV5    = `SJT_IR_RSV5,
		IR_RSV6    = `SJT_IR_RSV6,
		IR_BYPASS  = `SJT_IR_BYPASS
	} sjt_ir_t;

	// control handed from the test clock to the sram clock
	typedef struct packed {
		logic                  drive_en;
		logic                  q_oe;
		logic [`SJT_BSR_W-1:0] drive;
	} sjt_ctl_t;

endpackage : sjt_pkg

// >>> rtl/sjt_tap.sv
// boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/1ps
`default_nettype none
`include "sjt_defs.svh"

// Function
// R1: sample tdi on rising tck, change tdo only on falling tck.
// R2: exactly one data register sits between tdi and tdo, chosen by instruction.
// R3: instruction register is three bits, loaded serially while connected.
// R4: at power-up and in reset state the instruction becomes identification.
// R5: capture-ir loads the two low instruction bits with binary 01.
// R6: bypass is one bit, loaded low when bypass executes.
// R7: capture-dr loads pin ring into boundary register; shift-dr connects it.
// R8: boundary register msb fed from tdi, lsb drives tdo.
// R9: identification instruction loads hardwired 32-bit code at capture-dr, shifts out.
// R10: instructions shift in shift-ir and take effect only at update-ir.
// R11: tester never loads the three reserved codes.
// R12: sample-high-z connects boundary register and floats output bus until update-ir.
// R13: sample/preload capture-dr snapshots all pin values into boundary register.
// R14: tester stops sram clock during sampling or ignores its captured bits; the bench keeps mclk running and checks them, holding ring_in still.
// R15: preload puts shifted pattern on latched outputs; sample and preload overlap.
// R16: bypass instruction connects the single bypass bit during shift-dr.
// R17: external test drives preloaded values to outputs, boundary register shifts.
// R18: cell 47 latched at update-dr enables output bus under external test.
// R19: output-enable cell preset high at power-up and in test-logic-reset.
// R20: codes: extest 000, id 001, sample-z 010, sample 100, bypass 111.
// R21: five rising tck edges with tms high reset the controller.
// R22: power-up resets test logic so tdo starts at high impedance.
// R23: controller follows the sixteen-state scan sequence, steered by sampled tms.
module sjt_tap #(
	parameter logic [31:0] ID_CODE = 32'h0abc_d123 // arbitrary value
) (
	input  wire logic                  mclk,
	input  wire logic                  reset_n,
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	input  wire logic [`SJT_BSR_W-1:0] ring_in,
	output var  logic                  tdo_out,
	output var  logic                  tdo_oe,
	output var  sjt_pkg::sjt_ctl_t     sram_ctl
);
	import sjt_pkg::*;

	localparam int BW = `SJT_BSR_W;
	localparam int OE = `SJT_OE_BIT;

	function automatic sjt_state_t tap_next(input sjt_state_t s, input logic m);
		sjt_state_t n;
		n = s;
		unique case (s)
			ST_TLR: n = m ? ST_TLR : ST_RTI;
			ST_RTI: n = m ? ST_SDS : ST_RTI;
			ST_SDS: n = m ? ST_SIS : ST_CDR;
			ST_CDR: n = m ? ST_E1D : ST_SDR;
			ST_SDR: n = m ? ST_E1D : ST_SDR;
			ST_E1D: n = m ? ST_UDR : ST_PDR;
			ST_PDR: n = m ? ST_E2D : ST_PDR;
			ST_E2D: n = m ? ST_UDR : ST_SDR;
			ST_UDR: n = m ? ST_SDS : ST_RTI;
			ST_SIS: n = m ? ST_TLR : ST_CIR;
			ST_CIR: n = m ? ST_E1I : ST_SIR;
			ST_SIR: n = m ? ST_E1I : ST_SIR;
			ST_E1I: n = m ? ST_UIR : ST_PIR;
			ST_PIR: n = m ? ST_E2I : ST_PIR;
			ST_E2I: n = m ? ST_UIR : ST_SIR;
			ST_UIR: n = m ? ST_SDS : ST_RTI;
		endcase
		return n;
	endfunction : tap_next

	// test logic reset follows reset_n, brought into the tck domain
	logic rst1_r;
	logic rst2_r;
	logic tap_rst;

	always_ff @(posedge tck) begin
		rst1_r <= reset_n;
		rst2_r <= rst1_r;
	end

	assign tap_rst = !rst2_r;

	// pin ring is asynchronous to tck; settle it before capture
	logic [BW-1:0] ring1_r;
	logic [BW-1:0] ring2_r;

	always_ff @(posedge tck) begin
		ring1_r <= ring_in;
		ring2_r <= ring1_r;
	end

	sjt_state_t        state_r, state_nxt;
	sjt_ir_t           ir_r, ir_nxt;
	logic [2:0]        irsh_r, irsh_nxt;
	logic              byp_r, byp_nxt;
	logic [31:0]       id_r, id_nxt;
	logic [BW-1:0]     bsr_r, bsr_nxt;
	logic [BW-1:0]     upd_r, upd_nxt;
	sjt_ctl_t          ctl_r, ctl_nxt;
	logic              tog_r, tog_nxt;
	logic              bsr_sel;
	logic              id_sel;
	logic              byp_sel;

	// reserved codes fall back to the bypass path so the chain length stays defined
	assign bsr_sel = (ir_r == IR_EXTEST) || (ir_r == IR_SAMPLEZ)
		|| (ir_r == IR_SAMPLE); // [R20]
	assign id_sel  = (ir_r == IR_IDCODE); // [R20]
	assign byp_sel = !bsr_sel && !id_sel; // [R2] [R16]

	always_comb begin
		state_nxt = tap_next(state_r, tms); // [R23] [R21]
		ir_nxt    = ir_r;
		irsh_nxt  = irsh_r;
		byp_nxt   = byp_r;
		id_nxt    = id_r;
		bsr_nxt   = bsr_r;
		upd_nxt   = upd_r;
		case (state_r)
			ST_TLR: begin
				ir_nxt      = IR_IDCODE; // [R4]
				upd_nxt[OE] = 1'b1; // [R19]
			end
			ST_CIR: irsh_nxt = {1'b0, `SJT_IR_CAP}; // [R5]
			ST_SIR: irsh_nxt = {tdi, irsh_r[2:1]}; // [R3] [R1]
			ST_UIR: ir_nxt = sjt_ir_t'(irsh_r); // [R10]
			ST_CDR: begin
				if (byp_sel) begin
					byp_nxt = 1'b0; // [R6]
				end
				if (id_sel) begin
					id_nxt = ID_CODE; // [R9]
				end
				if (bsr_sel) begin
					bsr_nxt = ring2_r; // [R7] [R13]
				end
			end
			ST_SDR: begin
				if (byp_sel) begin
					byp_nxt = tdi; // [R16]
				end
				if (id_sel) begin
					id_nxt = {tdi, id_r[31:1]}; // [R9]
				end
				if (bsr_sel) begin
					bsr_nxt = {tdi, bsr_r[BW-1:1]}; // [R8] [R15]
				end
			end
			ST_UDR: begin
				if (ir_r == IR_EXTEST || ir_r == IR_SAMPLE) begin
					upd_nxt = bsr_r; // [R15] [R18]
				end
			end
			default: ;
		endcase
		// from the next values, so the pins follow update-ir and update-dr at once
		// instead of waiting for a further tck rise that the tester may never give
		ctl_nxt.drive_en = (ir_nxt == IR_EXTEST); // [R17]
		ctl_nxt.q_oe     = !(ir_nxt == IR_SAMPLEZ)
			&& !(ir_nxt == IR_EXTEST && !upd_nxt[OE]); // [R12] [R18]
		ctl_nxt.drive    = upd_nxt; // [R17]
		tog_nxt          = tog_r ^ (ctl_nxt != ctl_r);
		if (tap_rst) begin
			state_nxt   = ST_TLR; // [R22]
			ir_nxt      = IR_IDCODE; // [R4]
			irsh_nxt    = '0;
			byp_nxt     = 1'b0;
			id_nxt      = '0;
			bsr_nxt     = '0;
			upd_nxt     = '0;
			upd_nxt[OE] = 1'b1; // [R19]
			ctl_nxt     = '0;
			ctl_nxt.q_oe = 1'b1;
			tog_nxt     = 1'b0;
		end
	end

	always_ff @(posedge tck) begin
		state_r <= state_nxt;
		ir_r    <= ir_nxt;
		irsh_r  <= irsh_nxt;
		byp_r   <= byp_nxt;
		id_r    <= id_nxt;
		bsr_r   <= bsr_nxt;
		upd_r   <= upd_nxt;
		ctl_r   <= ctl_nxt;
		tog_r   <= tog_nxt;
	end

	// serial output moves on the falling edge, half a cycle after the shift
	logic tdo_r, tdo_nxt;
	logic toe_r, toe_nxt;

	always_comb begin
		if (state_r == ST_SIR) begin
			tdo_nxt = irsh_r[0]; // [R3]
		end else if (bsr_sel) begin
			tdo_nxt = bsr_r[0]; // [R8]
		end else if (id_sel) begin
			tdo_nxt = id_r[0];
		end else begin
			tdo_nxt = byp_r;
		end
		toe_nxt = !tap_rst && (state_r == ST_SIR || state_r == ST_SDR); // [R22]
		if (tap_rst) begin
			tdo_nxt = 1'b0;
		end
	end

	always_ff @(negedge tck) begin
		tdo_r <= tdo_nxt; // [R1]
		toe_r <= toe_nxt; // [R1]
	end

	assign tdo_out = tdo_r;
	assign tdo_oe  = toe_r;

	// only the change flag is synchronised; the word is taken once the flag has settled,
	// so tck logic has held it two mclk periods by then. a later change is caught next flag
	logic     tsy1_r, tsy1_nxt;
	logic     tsy2_r, tsy2_nxt;
	logic     tsy3_r, tsy3_nxt;
	sjt_ctl_t cs2_r, cs2_nxt;

	always_comb begin
		tsy1_nxt = tog_r;
		tsy2_nxt = tsy1_r;
		tsy3_nxt = tsy2_r;
		cs2_nxt  = cs2_r;
		if (tsy2_r != tsy3_r) begin
			cs2_nxt = ctl_r; // [R12] [R17] [R18]
		end
		if (!reset_n) begin
			cs2_nxt      = '0;
			cs2_nxt.q_oe = 1'b1; // [R19]
		end
	end

	always_ff @(posedge mclk) begin
		tsy1_r <= tsy1_nxt;
		tsy2_r <= tsy2_nxt;
		tsy3_r <= tsy3_nxt;
		cs2_r  <= cs2_nxt;
	end

	assign sram_ctl = cs2_r;

	ir_capture_a: assert property (@(posedge tck) disable iff (tap_rst) // [R5]
		state_r == ST_CIR |=> irsh_r[1:0] == `SJT_IR_CAP)
		else $error("capture-ir pattern wrong");

	ir_hold_a: assert property (@(posedge tck) disable iff (tap_rst) // [R10]
		state_r != ST_UIR && state_r != ST_TLR |=> $stable(ir_r))
		else $error("instruction changed outside update-ir");

	ir_reset_a: assert property (@(posedge tck) disable iff (tap_rst) // [R4]
		state_r == ST_TLR |=> ir_r == IR_IDCODE)
		else $error("reset state did not load identification");

	tms_reset_a: assert property (@(posedge tck) disable iff (tap_rst) // [R21]
		tms [*5] |=> state_r == ST_TLR)
		else $error("five tms highs did not reset controller");

	byp_cap_a: assert property (@(posedge tck) disable iff (tap_rst) // [R6]
		state_r == ST_CDR && ir_r == IR_BYPASS |=> !byp_r)
		else $error("bypass not captured low");

	id_cap_a: assert property (@(posedge tck) disable iff (tap_rst) // [R9]
		state_r == ST_CDR && id_sel |=> id_r == ID_CODE)
		else $error("identification code not captured");

	bsr_shift_a: assert property (@(posedge tck) disable iff (tap_rst) // [R8]
		state_r == ST_SDR && bsr_sel |=> bsr_r[BW-1] == $past(tdi)
			&& bsr_r[BW-2:0] == $past(bsr_r[BW-1:1]))
		else $error("boundary shift path wrong");

	oe_cell_a: assert property (@(posedge tck) disable iff (tap_rst) // [R19]
		state_r == ST_TLR |=> upd_r[OE])
		else $error("output-enable cell not preset");

	upd_ext_a: assert property (@(posedge tck) disable iff (tap_rst) // [R18]
		state_r == ST_UDR && ir_r == IR_EXTEST |=> ctl_r.q_oe == upd_r[OE])
		else $error("output bus enable does not follow cell 47");

	ir_shift_a: assert property (@(posedge tck) disable iff (tap_rst) // [R3]
		state_r == ST_SIR |=> irsh_r == {$past(tdi), $past(irsh_r[2:1])})
		else $error("instruction shift path wrong");

	ir_update_a: assert property (@(posedge tck) disable iff (tap_rst) // [R10]
		state_r == ST_UIR |=> ir_r == $past(irsh_r))
		else $error("instruction not taken at update-ir");

	byp_shift_a: assert property (@(posedge tck) disable iff (tap_rst) // [R16]
		state_r == ST_SDR && byp_sel |=> byp_r == $past(tdi))
		else $error("bypass bit did not take tdi");

	tdo_drive_a: assert property (@(posedge tck) disable iff (tap_rst) // [R22]
		state_r == ST_SIR || state_r == ST_SDR |-> tdo_oe)
		else $error("tdo not driven while shifting");

	tdo_float_a: assert property (@(posedge tck) disable iff (tap_rst) // [R22]
		state_r == ST_TLR || state_r == ST_RTI |-> !tdo_oe)
		else $error("tdo driven outside shift");

	sram_reset_a: assert property (@(posedge mclk) // [R19]
		!reset_n |=> sram_ctl.q_oe && !sram_ctl.drive_en)
		else $error("sram control not at reset value");

endmodule : sjt_tap
`default_nettype wire

// >>> dv/sjt_tester.sv
// tester model: drives tck only within frames, plus tms and tdi
`timescale 1ns/1ps
`default_nettype none
module sjt_tester (
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo_out,
	input  wire logic tdo_oe
);
	logic oe_ok;
	logic last_oe;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		oe_ok = 1'b1;
		last_oe = 1'b0;
	end
	// 80 ns period; tms and tdi move just after the fall, tdo read before the rise
	task automatic pulse(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40;
		q = tdo_out;
		last_oe = tdo_oe;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask : pulse
	// from idle: capture, shift n bits lsb first, update, idle
	task automatic scan(input logic ir, input int n, input logic [106:0] din,
			output logic [106:0] dout);
		logic q;
		dout = '0;
		oe_ok = 1'b1;
		pulse(1'b1, 1'b1, q);
		if (ir) pulse(1'b1, 1'b1, q);
		pulse(1'b0, 1'b1, q);
		pulse(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], q);
			dout[i] = q;
			if (last_oe !== 1'b1) oe_ok = 1'b0;
		end
		pulse(1'b1, 1'b1, q);
		pulse(1'b0, 1'b1, q);
	endtask : scan
	// tdi idles high as if pulled up; five tms-high rises then idle
	task automatic reset5();
		logic q;
		repeat (5) pulse(1'b1, 1'b1, q);
		pulse(1'b0, 1'b1, q);
	endtask : reset5
endmodule : sjt_tester
`default_nettype wire

// >>> dv/sjt_tap_tb.sv
// self-checking bench of the boundary-scan port
`timescale 1ns/1ps
`default_nettype none
`include "sjt_defs.svh"
module sjt_tap_tb;
	import sjt_pkg::*;
	typedef struct packed {
		logic [2:0] code;
		logic       q_oe;
		logic       drive_en;
	} sjt_row_t;
	localparam logic [31:0] TB_ID = 32'h5a5a_0f0f; // arbitrary value
	logic                  mclk, reset_n, tck, tms, tdi, tdo_out, tdo_oe, bq;
	logic [`SJT_BSR_W-1:0] ring_in, p, qv, dout;
	sjt_ctl_t              sram_ctl;
	int                    error_cnt, cmp_count;
	sjt_row_t              rows [5];

	sjt_tap #(.ID_CODE(TB_ID)) dut (.mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms),
		.tdi(tdi), .ring_in(ring_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .sram_ctl(sram_ctl));
	sjt_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

	always #12.5 mclk = ~mclk;

	task automatic chk(input string what, input logic [106:0] exp, input logic [106:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// only the five implemented codes are ever loaded
	task automatic load_ir(input logic [2:0] code);
		logic [106:0] o;
		tester.scan(1'b1, 3, {104'h0, code}, o);
		chk("ir capture", 107'h1, o);
		repeat (8) @(negedge mclk);
	endtask : load_ir

	// tdo may only move while tck is low
	always @(tdo_out) if (tck !== 1'b0) begin
		error_cnt++;
		$display("[ERR] tdo_out expected change at fall seen change at tck high");
	end

	initial begin
		#200000;
		error_cnt++;
		$display("[ERR] watchdog expected end seen timeout");
		tally_and_finish();
	end

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		p = {11'h5a3, 32'hdead_beef, 32'h0123_4567, 32'h89ab_cdef};
		ring_in = p; // pins held still across capture
		rows = '{'{`SJT_IR_IDCODE, 1'b1, 1'b0}, '{`SJT_IR_SAMPLEZ, 1'b0, 1'b0},
			'{`SJT_IR_BYPASS, 1'b1, 1'b0}, '{`SJT_IR_SAMPLE, 1'b1, 1'b0},
			'{`SJT_IR_EXTEST, 1'b1, 1'b1}};
		fork
			repeat (10) @(negedge mclk);
			repeat (3) tester.pulse(1'b1, 1'b1, bq);
		join
		@(negedge mclk);
		reset_n = 1'b1;
		chk("q_oe", 1'b1, sram_ctl.q_oe);
		chk("drive_en", 1'b0, sram_ctl.drive_en);
		chk("tdo_oe", 1'b0, tdo_oe);
		tester.reset5();
		tester.scan(1'b0, 32, '0, dout);
		chk("idcode", TB_ID, dout);
		chk("tdo_oe shift", 1'b1, tester.oe_ok);
		$display("reset and id test done");
		// cell 47 still preset high, so extest keeps the bus enabled
		foreach (rows[i]) begin
			load_ir(rows[i].code);
			chk("q_oe", rows[i].q_oe, sram_ctl.q_oe);
			chk("drive_en", rows[i].drive_en, sram_ctl.drive_en);
			$display("row %0d done", i);
		end
		load_ir(`SJT_IR_BYPASS);
		tester.scan(1'b0, 2, 107'h3, dout);
		chk("bypass", 107'h2, dout);
		$display("bypass test done");
		load_ir(`SJT_IR_SAMPLE);
		qv = ~p;
		qv[`SJT_OE_BIT] = 1'b0;
		tester.scan(1'b0, `SJT_BSR_W, qv, dout);
		chk("capture", p, dout);
		chk("tdo_oe shift", 1'b1, tester.oe_ok);
		repeat (8) @(negedge mclk);
		chk("preload", qv, sram_ctl.drive);
		load_ir(`SJT_IR_EXTEST);
		chk("q_oe", 1'b0, sram_ctl.q_oe);
		chk("drive_en", 1'b1, sram_ctl.drive_en);
		chk("drive", qv, sram_ctl.drive);
		tester.scan(1'b0, `SJT_BSR_W, ~qv, dout);
		chk("extest capture", p, dout);
		repeat (8) @(negedge mclk);
		chk("q_oe", 1'b1, sram_ctl.q_oe);
		chk("drive", ~qv, sram_ctl.drive);
		$display("sample and extest test done");
		tester.reset5();
		repeat (8) @(negedge mclk);
		chk("q_oe", 1'b1, sram_ctl.q_oe);
		chk("drive_en", 1'b0, sram_ctl.drive_en);
		tester.scan(1'b0, 32, '0, dout);
		chk("idcode", TB_ID, dout);
		$display("tms reset test done");
		tally_and_finish();
	end
endmodule : sjt_tap_tb
`default_nettype wire
